// ### src/ppc_pkg.sv
// Package for the power and configuration register bank.
// Assumes an 8-bit register port with byte offsets held below.
package ppc_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [7:0] OFF_PAGE      = 8'he0;
  localparam logic [7:0] OFF_PM_CLOCK  = 8'hb0;
  localparam logic [7:0] OFF_PM_INPUT  = 8'hb4;
  localparam logic [7:0] OFF_MEM_SPACE = 8'he2;
  localparam logic [7:0] OFF_MAIN_ID   = 8'hf0;
  localparam logic [7:0] OFF_SEC_ID    = 8'hf1;

  // ==========================================================================
  // Writable bit masks and reset values.
  localparam logic [7:0] PM_CLOCK_MASK  = 8'h3a;
  localparam logic [7:0] PM_INPUT_MASK  = 8'h7d;
  localparam logic [7:0] MEM_SPACE_MASK = 8'h9f;
  localparam logic [7:0] PAGE_RESET     = 8'h00;
  localparam logic [7:0] PM_RESET       = 8'h00;
  localparam logic [7:0] MEM_LOAD_MASK  = 8'h1e;
  localparam logic [7:0] SEC_ID_MASK    = 8'h3f;

  // ==========================================================================
  // Field positions.
  localparam int PM_APD_BIT    = 1;
  localparam int PM_TURBO_BIT  = 3;
  localparam int PM_ARRAY_BIT  = 4;
  localparam int PM_MCELL_BIT  = 5;
  localparam int IG_ADDR_BIT   = 0;
  localparam int IG_CTRL_LSB   = 2;
  localparam int IG_ALE_BIT    = 5;
  localparam int IG_WRH_BIT    = 6;
  localparam int MS_SRAM_CODE  = 0;
  localparam int MS_SEC_CODE   = 1;
  localparam int MS_PRI_CODE   = 2;
  localparam int MS_SEC_DATA   = 3;
  localparam int MS_PRI_DATA   = 4;
  localparam int MS_PERIPH_BIT = 7;

  // State of the register bank.
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] pm_clock;
    logic [7:0] pm_input;
    logic [7:0] mem_space;
    logic [7:0] rdata;
    logic       pwr_done;
  } ppc_state_type;

endpackage

// ### src/ppc_bus_if.sv
// Interface carrying register values into the gating logic.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface ppc_bus_if;
  logic [7:0] pm_input;   // Input gate register value.
  logic [7:0] mem_space;  // Memory space register value.
  modport src (output pm_input, output mem_space);
  modport dst (input pm_input, input mem_space);
endinterface

// ### src/ppc_gate.sv
// Gating of array inputs and memory access permissions.
// Assumes register values come from the bank on the same clock.
`timescale 1ns/1ns
module ppc_gate (
  input  wire logic       i_clk,                   // Clock.
  input  wire logic       i_nrst,                  // Asynchronous reset, active low.
  ppc_bus_if.dst          regs,                    // Register values.
  input  wire logic       i_split_bus,             // Split program/data bus mode.
  input  wire logic [7:0] i_addr,                  // Synchronised address low byte.
  input  wire logic [3:0] i_low_address_port_pins, // Port pins, split mode.
  input  wire logic [2:0] i_ctrl,                  // Synchronised control inputs a..c.
  input  wire logic       i_ale,                   // Synchronised address latch strobe.
  input  wire logic       i_hbw,                   // Synchronised high byte write enable.
  output logic [7:0]      o_addr,                  // Address seen by the array.
  output logic [2:0]      o_ctrl,                  // Control inputs seen by the array.
  output logic            o_ale,                   // Strobe seen by the array.
  output logic            o_hbw,                   // High byte enable seen by the array.
  output logic [4:0]      o_access                 // Access permissions.
);
  logic [7:0] addr_src;

  assign addr_src = i_split_bus ? {i_addr[7:4], i_low_address_port_pins} : i_addr;

  // Register the gated signals so the top outputs come from flip-flops.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_addr   <= 8'h00;
      o_ctrl   <= 3'h0;
      o_ale    <= 1'b0;
      o_hbw    <= 1'b0;
      o_access <= 5'h00;
    end else begin
      o_addr <= regs.pm_input[ppc_pkg::IG_ADDR_BIT] ? 8'h00 : addr_src;
      o_ctrl <= i_ctrl & ~regs.pm_input[ppc_pkg::IG_CTRL_LSB +: 3];
      o_ale  <= i_ale & ~regs.pm_input[ppc_pkg::IG_ALE_BIT];
      o_hbw  <= i_hbw & ~regs.pm_input[ppc_pkg::IG_WRH_BIT];
      o_access <= i_split_bus ? regs.mem_space[4:0] : 5'h1f;
    end
  end
endmodule

// ### src/ppc_regs.sv
// Power and configuration register bank with its array input gating.
// Assumes a plain register port on the same clock and pins already in
// need of synchronising.
// Notes on behaviour
// - Page value feeds the logic array and resets to zero.
// - Clock control register clears at power-up only, not on later resets.
// - Clock control bit 1 enables automatic power-down.
// - Clock control bit 3 at zero means fast mode on.
// - Bit 4 disconnects array clock; clock changes wake array when slow and bit 4 is clear.
// - Bit 5 disconnects the macrocell clock.
// - Input gate bit 0 blocks the low address byte.
// - Split mode takes low address nibble from port pins.
// - Input gate bits 2 to 4 block the three control inputs.
// - Input gate bit 5 blocks the address latch strobe.
// - Input gate bit 6 blocks the high byte write enable.
// - Memory space bits 1 to 4 load user values at reset, 0 and 7 clear.
// - Memory space bits 0 to 4 matter only in split mode.
// - Bits 0 to 2 permit program strobe access to each memory.
// - Bits 3 and 4 permit read strobe access to secondary and primary memory.
// - Memory space bit 7 enables port peripheral mode.
// - Main id low nibble gives primary flash size code.
// - Main id high nibble gives SRAM size code.
// - Secondary id low nibble gives secondary memory size code.
// - Secondary id bits 5:4 give type, bits 7:6 read zero.
// - Secondary id register is read only.
`timescale 1ns/1ns
module ppc_regs #(
  parameter logic [3:0] PRI_SIZE = 4'h5,  // Primary flash size code.
  parameter logic [3:0] SRAM_SIZE = 4'h3, // SRAM size code.
  parameter logic [3:0] SEC_SIZE = 4'h2,  // Secondary memory size code.
  parameter logic [1:0] SEC_TYPE = 2'h0   // Secondary memory type code.
) (
  input  wire logic       i_clk,          // Clock, 125 MHz.
  input  wire logic       i_nrst,         // Asynchronous reset, active low.
  input  wire logic       i_npor,         // Power-up reset, active low.
  input  wire logic [7:0] i_addr,         // Register address.
  input  wire logic [7:0] i_wdata,        // Register write data.
  input  wire logic       i_wr,           // Write strobe.
  input  wire logic       i_rd,           // Read strobe.
  output logic [7:0]      o_rdata,        // Read data, cycle after strobe.
  input  wire logic [7:0] i_mem_cfg,      // User memory space reset values.
  input  wire logic       i_split_bus,    // Split bus mode strap.
  input  wire logic       i_logic_clock_input,     // Array clock pin.
  input  wire logic [7:0] i_bus_addr,     // Bus address low byte pins.
  input  wire logic [3:0] i_low_address_port_pins, // Port pins for split mode.
  input  wire logic [2:0] i_control_input,         // Control input pins a..c.
  input  wire logic       i_ale,          // Address latch strobe pin.
  input  wire logic       i_high_byte_write_enable, // High byte enable pin.
  output logic [7:0]      o_page_bits,    // Page value to the array.
  output logic            o_auto_powerdown,  // Automatic power-down enable.
  output logic            o_fast_mode,    // Array fast mode on.
  output logic            o_array_clk,    // Clock to the AND array.
  output logic            o_array_wake,   // Array wake pulse.
  output logic            o_mcell_clk,    // Clock to the macrocells.
  output logic [7:0]      o_array_addr,   // Address seen by the array.
  output logic [2:0]      o_array_ctrl,   // Control inputs seen by the array.
  output logic            o_array_ale,    // Strobe seen by the array.
  output logic            o_array_hbw,    // High byte enable seen by array.
  output logic            o_sram_program_access,    // Program strobe to SRAM.
  output logic            o_sec_program_access,     // Program strobe to NVM.
  output logic            o_primary_program_access, // Program strobe to flash.
  output logic            o_sec_data_access,        // Read strobe to NVM.
  output logic            o_primary_data_access,    // Read strobe to flash.
  output logic            o_periph_mode   // Port peripheral mode enable.
);

  // ==========================================================================
  // Pin synchronisers.
  localparam int SYNC_W = 19;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              clk_prev_q;
  logic              pm_clk_q;
  logic              mcell_q;
  logic              wake_q;
  logic [4:0]        access;
  ppc_pkg::ppc_state_type s_q;
  ppc_pkg::ppc_state_type s_d;
  logic [7:0]        pm_clock_q;
  logic [7:0]        pm_clock_d;
  logic              fast_q;

  // Two flip-flops on every pin input.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {i_logic_clock_input, i_bus_addr, i_low_address_port_pins,
                  i_control_input, i_ale, i_high_byte_write_enable, i_split_bus};
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================================
  // Register file.
  // Next state from bus writes; reads answer one cycle later.
  always_comb begin
    s_d       = s_q;
    s_d.rdata = 8'h00;
    s_d.pwr_done = 1'b1;
    if (!s_q.pwr_done) begin
      s_d.mem_space = i_mem_cfg & ppc_pkg::MEM_LOAD_MASK;
    end
    if (i_wr) begin
      unique case (i_addr)
        ppc_pkg::OFF_PAGE:      s_d.page = i_wdata;
        ppc_pkg::OFF_PM_INPUT:  s_d.pm_input = i_wdata & ppc_pkg::PM_INPUT_MASK;
        ppc_pkg::OFF_MEM_SPACE: s_d.mem_space = i_wdata & ppc_pkg::MEM_SPACE_MASK;
        default: ;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        ppc_pkg::OFF_PAGE:      s_d.rdata = s_q.page;
        ppc_pkg::OFF_PM_CLOCK:  s_d.rdata = pm_clock_q;
        ppc_pkg::OFF_PM_INPUT:  s_d.rdata = s_q.pm_input;
        ppc_pkg::OFF_MEM_SPACE: s_d.rdata = s_q.mem_space;
        ppc_pkg::OFF_MAIN_ID:   s_d.rdata = {SRAM_SIZE, PRI_SIZE};
        ppc_pkg::OFF_SEC_ID:    s_d.rdata = {2'h0, SEC_TYPE, SEC_SIZE} &
                                            ppc_pkg::SEC_ID_MASK;
        default:                s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Clock control write path.
  always_comb begin
    pm_clock_d = pm_clock_q;
    if (i_wr && i_addr == ppc_pkg::OFF_PM_CLOCK) begin
      pm_clock_d = i_wdata & ppc_pkg::PM_CLOCK_MASK;
    end
  end

  // only power-up clears it.
  // The fast mode flag lives in its own flop so the output needs no inverter.
  always_ff @(posedge i_clk or negedge i_npor) begin
    if (!i_npor) begin
      pm_clock_q <= ppc_pkg::PM_RESET;
      fast_q     <= ~ppc_pkg::PM_RESET[ppc_pkg::PM_TURBO_BIT];
    end else begin
      pm_clock_q <= pm_clock_d;
      // fast mode on while bit 3 is zero.
      fast_q     <= ~pm_clock_d[ppc_pkg::PM_TURBO_BIT];
    end
  end

  // ==========================================================================
  // Power management outputs.
  // Gate the synchronised array clock and detect its changes.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_prev_q <= 1'b0;
      pm_clk_q   <= 1'b0;
      mcell_q    <= 1'b0;
      wake_q     <= 1'b0;
    end else begin
      clk_prev_q <= sync2_q[18];
      pm_clk_q   <= sync2_q[18] & ~pm_clock_q[ppc_pkg::PM_ARRAY_BIT];
      mcell_q    <= sync2_q[18] & ~pm_clock_q[ppc_pkg::PM_MCELL_BIT];
      wake_q     <= (sync2_q[18] != clk_prev_q) &
                    ~pm_clock_q[ppc_pkg::PM_ARRAY_BIT] &
                    pm_clock_q[ppc_pkg::PM_TURBO_BIT];
    end
  end

  ppc_bus_if bus ();
  assign bus.pm_input  = s_q.pm_input;
  assign bus.mem_space = s_q.mem_space;

  // Input gating and access permissions.
  ppc_gate u_gate (
    .i_clk                   (i_clk),
    .i_nrst                  (i_nrst),
    .regs                    (bus),
    .i_split_bus             (sync2_q[0]),
    .i_addr                  (sync2_q[17:10]),
    .i_low_address_port_pins (sync2_q[9:6]),
    .i_ctrl                  (sync2_q[5:3]),
    .i_ale                   (sync2_q[2]),
    .i_hbw                   (sync2_q[1]),
    .o_addr                  (o_array_addr),
    .o_ctrl                  (o_array_ctrl),
    .o_ale                   (o_array_ale),
    .o_hbw                   (o_array_hbw),
    .o_access                (access)
  );

  // Outputs straight from flip-flops.
  assign o_rdata                  = s_q.rdata;
  assign o_page_bits              = s_q.page;
  assign o_auto_powerdown         = pm_clock_q[ppc_pkg::PM_APD_BIT];
  assign o_fast_mode              = fast_q;
  assign o_array_clk              = pm_clk_q;
  assign o_array_wake             = wake_q;
  assign o_mcell_clk              = mcell_q;
  assign o_sram_program_access    = access[ppc_pkg::MS_SRAM_CODE];
  assign o_sec_program_access     = access[ppc_pkg::MS_SEC_CODE];
  assign o_primary_program_access = access[ppc_pkg::MS_PRI_CODE];
  assign o_sec_data_access        = access[ppc_pkg::MS_SEC_DATA];
  assign o_primary_data_access    = access[ppc_pkg::MS_PRI_DATA];
  assign o_periph_mode            = s_q.mem_space[ppc_pkg::MS_PERIPH_BIT];

endmodule

// ### verif/ppc_regs_assertions.sv
// Port checker for the power and configuration register bank.
// Assumes it is bound onto ppc_regs with the same size codes.
`timescale 1ns/1ns
module ppc_regs_assertions #(
  parameter logic [3:0] PRI_SIZE  = 4'h5, // Primary size code.
  parameter logic [3:0] SRAM_SIZE = 4'h3, // SRAM size code.
  parameter logic [3:0] SEC_SIZE  = 4'h2, // Secondary size code.
  parameter logic [1:0] SEC_TYPE  = 2'h0  // Secondary type code.
) (
  input wire logic       i_clk,                    // Clock.
  input wire logic       i_nrst,                   // Reset, active low.
  input wire logic [7:0] i_addr,                   // Register address.
  input wire logic [7:0] i_wdata,                  // Write data.
  input wire logic       i_wr,                     // Write strobe.
  input wire logic       i_rd,                     // Read strobe.
  input wire logic [7:0] o_rdata,                  // Read data.
  input wire logic       i_split_bus,              // Split bus strap.
  input wire logic [7:0] o_page_bits,              // Page value.
  input wire logic       o_auto_powerdown,         // Power-down enable.
  input wire logic       o_fast_mode,              // Fast mode on.
  input wire logic       o_periph_mode,            // Peripheral mode.
  input wire logic       o_sram_program_access,    // Access flag.
  input wire logic       o_sec_program_access,     // Access flag.
  input wire logic       o_primary_program_access, // Access flag.
  input wire logic       o_sec_data_access,        // Access flag.
  input wire logic       o_primary_data_access     // Access flag.
);
  // ==========================================================================
  // Common clocking and sequences.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence page_wr;
    i_wr && i_addr == ppc_pkg::OFF_PAGE;
  endsequence
  sequence split_off;
    !i_split_bus [*4];
  endsequence

  // ==========================================================================
  // Register port relations.
  a_page_write: assert property (page_wr |=> o_page_bits == $past(i_wdata))
    else $error("page value not taken from write");
  a_page_hold: assert property (!(i_wr && i_addr == ppc_pkg::OFF_PAGE) |=>
    $stable(o_page_bits))
    else $error("page value changed without write");
  a_apd_write: assert property (i_wr && i_addr == ppc_pkg::OFF_PM_CLOCK |=>
    o_auto_powerdown == $past(i_wdata[1]))
    else $error("power-down enable wrong");
  a_fast_write: assert property (i_wr && i_addr == ppc_pkg::OFF_PM_CLOCK |=>
    o_fast_mode == !$past(i_wdata[3]))
    else $error("fast mode wrong");
  a_periph_write: assert property (i_wr && i_addr == ppc_pkg::OFF_MEM_SPACE |=>
    o_periph_mode == $past(i_wdata[7]))
    else $error("peripheral mode wrong");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data without read");
  a_read_unmapped: assert property (i_rd && !(i_addr inside {8'he0, 8'hb0, 8'hb4, 8'he2, 8'hf0,
    8'hf1}) |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_page_read: assert property (i_rd && i_addr == ppc_pkg::OFF_PAGE |=>
    o_rdata == $past(o_page_bits))
    else $error("page read mismatch");
  a_main_id: assert property (i_rd && i_addr == ppc_pkg::OFF_MAIN_ID |=>
    o_rdata == {SRAM_SIZE, PRI_SIZE})
    else $error("main id read wrong");
  a_sec_id: assert property (i_rd && i_addr == ppc_pkg::OFF_SEC_ID |=>
    o_rdata == {2'b00, SEC_TYPE, SEC_SIZE})
    else $error("secondary id read wrong");
  a_access_open: assert property (split_off |-> {o_primary_data_access, o_sec_data_access,
    o_primary_program_access, o_sec_program_access, o_sram_program_access} == 5'h1f)
    else $error("access restricted outside split mode");
endmodule
bind ppc_regs ppc_regs_assertions #(.PRI_SIZE(PRI_SIZE), .SRAM_SIZE(SRAM_SIZE),
  .SEC_SIZE(SEC_SIZE), .SEC_TYPE(SEC_TYPE)) u_chk (.i_clk, .i_nrst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_split_bus, .o_page_bits, .o_auto_powerdown, .o_fast_mode,
  .o_periph_mode, .o_sram_program_access, .o_sec_program_access, .o_primary_program_access,
  .o_sec_data_access, .o_primary_data_access);

// ### verif/ppc_host.sv
// Host model driving the register port.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ns
module ppc_host (
  input  wire logic [7:0] i_rdata, // Read data from the bank.
  input  wire logic       i_clk,   // Clock.
  output logic [7:0]      o_addr,  // Register address.
  output logic [7:0]      o_wdata, // Write data.
  output logic            o_wr,    // Write strobe.
  output logic            o_rd     // Read strobe.
);
  // ==========================================================================
  // Idle bus at time zero.
  initial begin
    {o_addr, o_wdata, o_wr, o_rd} = '0;
  end
  // One-cycle write; released data shows the inverse value.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
  endtask
  // One-cycle read, data taken in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    #1 d = i_rdata;
  endtask
endmodule

// ### verif/pld_power_config_regs_bench.sv
// Self-checking bench for the register bank and its array gating.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module pld_power_config_regs_bench;
  localparam logic [3:0] PRI = 4'h6;  // Largest primary size code.
  localparam logic [3:0] SRM = 4'h5;  // Largest SRAM size code.
  localparam logic [3:0] SEC = 4'h3;  // Largest secondary size code.
  localparam logic [1:0] TYP = 2'h1;  // Second type code.
  localparam logic [7:0] RA [6] = '{ppc_pkg::OFF_PAGE, ppc_pkg::OFF_PM_CLOCK,
    ppc_pkg::OFF_PM_INPUT, ppc_pkg::OFF_MEM_SPACE, ppc_pkg::OFF_MAIN_ID, ppc_pkg::OFF_SEC_ID};
  localparam logic [7:0] MK [4] = '{8'hff, ppc_pkg::PM_CLOCK_MASK, ppc_pkg::PM_INPUT_MASK,
    ppc_pkg::MEM_SPACE_MASK};
  logic        i_clk, i_nrst, i_npor, i_wr, i_rd, i_split_bus, i_logic_clock_input, i_ale;
  logic        i_high_byte_write_enable, o_auto_powerdown, o_fast_mode, o_array_clk;
  logic        o_array_wake, o_mcell_clk, o_array_ale, o_array_hbw, o_periph_mode;
  logic        o_sram_program_access, o_sec_program_access, o_primary_program_access;
  logic        o_sec_data_access, o_primary_data_access;
  logic [7:0]  i_addr, i_wdata, o_rdata, i_mem_cfg, i_bus_addr, o_page_bits, o_array_addr, d;
  logic [3:0]  i_low_address_port_pins;
  logic [2:0]  i_control_input, o_array_ctrl;
  logic [31:0] rnd;
  logic [7:0]  sh [4];
  int          n_mismatch, compares, n_wake, cyc, seed, k;

  // ==========================================================================
  // Design, host and clock.
  ppc_regs #(.PRI_SIZE(PRI), .SRAM_SIZE(SRM), .SEC_SIZE(SEC), .SEC_TYPE(TYP)) uut (.i_clk,
    .i_nrst, .i_npor, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_mem_cfg, .i_split_bus,
    .i_logic_clock_input, .i_bus_addr, .i_low_address_port_pins, .i_control_input, .i_ale,
    .i_high_byte_write_enable, .o_page_bits, .o_auto_powerdown, .o_fast_mode, .o_array_clk,
    .o_array_wake, .o_mcell_clk, .o_array_addr, .o_array_ctrl, .o_array_ale, .o_array_hbw,
    .o_sram_program_access, .o_sec_program_access, .o_primary_program_access,
    .o_sec_data_access, .o_primary_data_access, .o_periph_mode);
  ppc_host host (.i_rdata(o_rdata), .i_clk, .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
    .o_rd(i_rd));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // Wake pulse counter and hang limit.
  always @(posedge i_clk) begin
    cyc++;
    if (o_array_wake === 1'b1) n_wake++;
    if (cyc == 4000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Expectations and checks.
  function automatic logic [7:0] exp_reg(int j);
    return j < 4 ? sh[j] : (j == 4 ? {SRM, PRI} : {2'b00, TYP, SEC});
  endfunction
  function automatic logic [15:0] exp_pins();
    logic [7:0] a;
    a = i_split_bus ? {i_bus_addr[7:4], i_low_address_port_pins} : i_bus_addr;
    return {sh[2][0] ? 8'h00 : a, i_control_input & ~sh[2][4:2], i_ale & ~sh[2][5],
      i_high_byte_write_enable & ~sh[2][6], i_logic_clock_input & ~sh[1][4],
      i_logic_clock_input & ~sh[1][5], 1'b0};
  endfunction
  function automatic logic [15:0] exp_stat();
    return {sh[0], sh[1][1], ~sh[1][3], sh[3][7], i_split_bus ? sh[3][4:0] : 5'h1f};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input int j);
    logic [7:0] r;
    host.rd(RA[j], r);
    chk({8'h00, r}, {8'h00, exp_reg(j)});
  endtask
  task automatic pulse(input logic por);
    @(posedge i_clk);
    if (por) i_npor <= 1'b0;
    else i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    {i_nrst, i_npor} <= 2'b11;
    @(posedge i_clk);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence: reset values, random traffic, resets, wake pulses.
  initial begin
    seed = 32'h1e220aff;
    {i_nrst, i_npor, i_split_bus, i_logic_clock_input, i_ale, i_high_byte_write_enable} = '0;
    {i_bus_addr, i_low_address_port_pins, i_control_input} = '0;
    i_mem_cfg = 8'hff;
    repeat (2) @(posedge i_clk);
    {i_nrst, i_npor} <= 2'b11;
    @(posedge i_clk);
    sh = '{8'h00, 8'h00, 8'h00, 8'h1e};
    for (int j = 0; j < 6; j++) rd_chk(j);
    host.rd(8'hb1, d);
    chk({8'h00, d}, 16'h0000);
    repeat (60) begin
      rnd = $random(seed);
      k = rnd[31:20] % 6;
      d = rnd[27:20] ^ rnd[7:0];
      @(posedge i_clk);
      {i_split_bus, i_logic_clock_input, i_ale} <= rnd[6:4];
      {i_high_byte_write_enable, i_control_input} <= rnd[3:0];
      {i_bus_addr, i_low_address_port_pins} <= rnd[18:7];
      host.wr(RA[k], d);
      if (k < 4) sh[k] = d & MK[k];
      rd_chk(k);
      chk({o_array_addr, o_array_ctrl, o_array_ale, o_array_hbw, o_array_clk, o_mcell_clk, 1'b0},
        exp_pins());
      chk({o_page_bits, o_auto_powerdown, o_fast_mode, o_periph_mode, o_primary_data_access,
        o_sec_data_access, o_primary_program_access, o_sec_program_access, o_sram_program_access},
        exp_stat());
    end
    host.wr(RA[0], 8'h5a);
    host.wr(RA[1], 8'h3a);
    i_mem_cfg <= 8'h0b;
    pulse(1'b0);
    sh = '{8'h00, 8'h3a, sh[2] & 8'h00, 8'h0a};
    for (int j = 0; j < 4; j++) rd_chk(j);
    host.wr(RA[0], 8'ha5);
    pulse(1'b1);
    sh = '{8'ha5, 8'h00, 8'h00, 8'h0a};
    for (int j = 0; j < 4; j++) rd_chk(j);
    for (int m = 0; m < 3; m++) begin
      host.wr(RA[1], m == 0 ? 8'h08 : (m == 1 ? 8'h18 : 8'h00));
      n_wake = 0;
      repeat (4) begin
        repeat (4) @(posedge i_clk);
        i_logic_clock_input <= ~i_logic_clock_input;
      end
      repeat (5) @(posedge i_clk);
      chk(n_wake[15:0], m == 0 ? 16'h0004 : 16'h0000);
    end
    tally_and_finish();
  end
endmodule
